// *** rtl/ptm_count_latch.sv ***
// Low count byte holding buffer armed by a high byte read.
`include "ptm_defines.svh"

module ptm_count_latch (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [`PTM_BYTE_W-1:0] count_low,
  input  wire logic                   read_high,
  input  wire logic                   read_low,
  output logic      [`PTM_BYTE_W-1:0] low_view
);

  ptm_pkg::ptm_latch_s st_r;
  ptm_pkg::ptm_latch_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    low_view = st_r.held ? st_r.low : count_low;
    if (read_low) begin
      st_nxt.held = 1'b0;
    end else if (read_high && !st_r.held) begin
      st_nxt.low = count_low;
      st_nxt.held = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// *** rtl/ptm_defines.svh ***
// Register indices, field positions, reset values and counts of the periodic timer.
`ifndef PTM_DEFINES_SVH
`define PTM_DEFINES_SVH

// Register indices; the byte address of each is four times its index.
`define PTM_IDX_STATUS_CONTROL 8'h4b
`define PTM_IDX_COUNT_HIGH     8'h4c
`define PTM_IDX_COUNT_LOW      8'h4d
`define PTM_IDX_MODULO_HIGH    8'h4e
`define PTM_IDX_MODULO_LOW     8'h4f

// Status and control field positions.
`define PTM_SC_FLAG_BIT   7
`define PTM_SC_IE_BIT     6
`define PTM_SC_STOP_BIT   5
`define PTM_SC_RST_BIT    4
`define PTM_SC_PPS_MSB    2
`define PTM_SC_PPS_LSB    0

// Widths and reset values.
`define PTM_CNT_W         16
`define PTM_PRE_W         7
`define PTM_PPS_W         3
`define PTM_DATA_W        32
`define PTM_BYTE_W        8
`define PTM_MOD_RESET     16'hffff
`define PTM_CNT_RESET     16'h0000
`define PTM_PPS_RESET     3'h0
`define PTM_PPS_MAX       3'h6

`endif

// *** rtl/ptm_pkg.sv ***
// Types shared by the periodic timer modules.
package ptm_pkg;

  typedef enum logic [2:0] {
    REG_NONE      = 3'b000,
    REG_SC        = 3'b001,
    REG_CNT_HIGH  = 3'b010,
    REG_CNT_LOW   = 3'b011,
    REG_MOD_HIGH  = 3'b100,
    REG_MOD_LOW   = 3'b101
  } ptm_reg_e;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] modulo;
    logic        overflow_flag;
    logic        overflow_interrupt_enable;
    logic        counter_stop;
    logic [2:0]  prescaler_select;
    logic        clear_armed;
    logic        mod_high_pending;
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
    logic        irq;
  } ptm_state_s;

  typedef struct packed {
    logic [6:0] div;
  } ptm_pre_s;

  typedef struct packed {
    logic [7:0] low;
    logic       held;
  } ptm_latch_s;

endpackage

// *** rtl/ptm_prescaler.sv ***
// Bus clock prescaler giving a one-cycle tick at the selected division.
`include "ptm_defines.svh"

module ptm_prescaler (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   run,
  input  wire logic                   clear,
  input  wire logic [`PTM_PPS_W-1:0]  prescaler_select,
  output logic                        tick
);

  ptm_pkg::ptm_pre_s st_r;
  ptm_pkg::ptm_pre_s st_nxt;
  logic [`PTM_PRE_W:0] ones;
  logic [`PTM_PPS_W-1:0] sel;

  assign ones[0] = 1'b1;

  // Tap k is true when the low k bits of the divider are all ones.
  genvar k;
  generate
    for (k = 1; k <= `PTM_PRE_W; k++) begin : g_tap
      assign ones[k] = ones[k-1] & st_r.div[k-1];
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    // Code seven falls back to the slowest rate.
    sel = (prescaler_select > `PTM_PPS_MAX) ? `PTM_PPS_MAX : prescaler_select;
    tick = run & ~clear & ones[sel];
    if (clear) begin
      st_nxt.div = '0;
    end else if (run) begin
      st_nxt.div = st_r.div + 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// *** rtl/ptm_timer.sv ***
// Periodic interrupt timer with its APB register slave.
// What this block does
// - Counter equal to modulo sets overflow flag.
// - Flag clears by read while set, then zero write.
// - Overflow between read and write voids the clear.
// - Writing one keeps flag; reset clears it.
// - Interrupt enable gates flag onto request.
// - Stop bit halts counting; reset sets it.
// - Counter reset bit clears counter and prescaler.
// - Counter reset bit self-clears, reads zero.
// - Stop plus reset together holds zero.
// - Select field divides bus clock 1 to 64.
// - High byte read latches low byte.
// - Latch held until low byte read.
// - Reset and counter reset clear counter.
// - At modulo, flag sets and counter restarts.
// - Modulo high write suppresses flag setting until low; counter still restarts.
// - Reset sets modulo to all ones.
// - Break freezes the counter.
// - Stop mode freezes timer, keeps state.
// - Wait mode keeps counting and may wake.
// - Break without clear enable protects status.
//
// Added by the designer: the APB interface to the registers and the address map.
`include "ptm_defines.svh"

module ptm_timer #(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              brk_active,
  input  wire logic              break_clear_enable,
  input  wire logic              stop_mode,
  output logic                   irq
);

  generate
    if (ADDR_W < 9) begin : g_addr_check
      $error("ADDR_W too small to reach the timer registers.");
    end
  endgenerate

  ptm_pkg::ptm_state_s st_r;
  ptm_pkg::ptm_state_s st_nxt;
  ptm_pkg::ptm_reg_e   reg_sel;

  logic [ADDR_W-3:0]        word_addr;
  logic                     access;
  logic                     commit;
  logic                     wr_commit;
  logic                     rd_commit;
  logic                     status_locked;
  logic                     counter_reset;
  logic                     run;
  logic                     tick;
  logic                     overflow;
  logic                     flag_set;
  logic [`PTM_BYTE_W-1:0]   low_view;
  logic [`PTM_BYTE_W-1:0]   wbyte;
  logic [`PTM_BYTE_W-1:0]   sc_view;

  assign word_addr = paddr[ADDR_W-1:2];
  assign access    = psel & penable;
  assign commit    = access & st_r.ready;
  assign wr_commit = commit & pwrite;
  assign rd_commit = commit & ~pwrite;
  assign wbyte     = pwdata[`PTM_BYTE_W-1:0];

  // Address decode on word index; byte lanes below bit two are ignored.
  always_comb begin
    if (word_addr == (ADDR_W-2)'(`PTM_IDX_STATUS_CONTROL)) begin
      reg_sel = ptm_pkg::REG_SC;
    end else if (word_addr == (ADDR_W-2)'(`PTM_IDX_COUNT_HIGH)) begin
      reg_sel = ptm_pkg::REG_CNT_HIGH;
    end else if (word_addr == (ADDR_W-2)'(`PTM_IDX_COUNT_LOW)) begin
      reg_sel = ptm_pkg::REG_CNT_LOW;
    end else if (word_addr == (ADDR_W-2)'(`PTM_IDX_MODULO_HIGH)) begin
      reg_sel = ptm_pkg::REG_MOD_HIGH;
    end else if (word_addr == (ADDR_W-2)'(`PTM_IDX_MODULO_LOW)) begin
      reg_sel = ptm_pkg::REG_MOD_LOW;
    end else begin
      reg_sel = ptm_pkg::REG_NONE;
    end
  end

  // Status accesses during a protected break leave the overflow flag and its clear arming alone.
  assign status_locked = brk_active & ~break_clear_enable;

  // The counter reset bit is never stored, so it reads as zero afterwards.
  assign counter_reset = wr_commit && (reg_sel == ptm_pkg::REG_SC)
                         && wbyte[`PTM_SC_RST_BIT];

  // Wait mode is not a gate here, so the timer keeps running in it.
  assign run = ~st_r.counter_stop & ~brk_active & ~stop_mode;

  ptm_prescaler u_prescaler (
    .pclk             (pclk),
    .presetn          (presetn),
    .run              (run),
    .clear            (counter_reset),
    .prescaler_select (st_r.prescaler_select),
    .tick             (tick)
  );

  ptm_count_latch u_count_latch (
    .pclk      (pclk),
    .presetn   (presetn),
    .count_low (st_r.count[`PTM_BYTE_W-1:0]),
    .read_high (rd_commit && (reg_sel == ptm_pkg::REG_CNT_HIGH)),
    .read_low  (rd_commit && (reg_sel == ptm_pkg::REG_CNT_LOW)),
    .low_view  (low_view)
  );

  assign overflow = tick & (st_r.count == st_r.modulo) & ~counter_reset;
  // A half written modulo value would give a bogus match, so it is muted.
  assign flag_set = overflow & ~st_r.mod_high_pending;

  assign sc_view = {st_r.overflow_flag,
                    st_r.overflow_interrupt_enable,
                    st_r.counter_stop,
                    1'b0,
                    1'b0,
                    st_r.prescaler_select};

  always_comb begin
    st_nxt = st_r;

    // Bus answer: one wait cycle, then pready with data already registered.
    st_nxt.ready = 1'b0;
    if (access && !st_r.ready) begin
      st_nxt.ready  = 1'b1;
      st_nxt.slverr = (reg_sel == ptm_pkg::REG_NONE);
      st_nxt.rdata  = '0;
      if (!pwrite) begin
        case (reg_sel)
          ptm_pkg::REG_SC: begin
            st_nxt.rdata[`PTM_BYTE_W-1:0] = sc_view;
          end
          ptm_pkg::REG_CNT_HIGH: begin
            st_nxt.rdata[`PTM_BYTE_W-1:0] = st_r.count[`PTM_CNT_W-1:`PTM_BYTE_W];
          end
          ptm_pkg::REG_CNT_LOW: begin
            st_nxt.rdata[`PTM_BYTE_W-1:0] = low_view;
          end
          ptm_pkg::REG_MOD_HIGH: begin
            st_nxt.rdata[`PTM_BYTE_W-1:0] = st_r.modulo[`PTM_CNT_W-1:`PTM_BYTE_W];
          end
          ptm_pkg::REG_MOD_LOW: begin
            st_nxt.rdata[`PTM_BYTE_W-1:0] = st_r.modulo[`PTM_BYTE_W-1:0];
          end
          default: begin
            st_nxt.rdata = '0;
          end
        endcase
      end
    end else if (!access) begin
      st_nxt.slverr = 1'b0;
    end

    // Counter: reset wins, then wrap at the modulo, else increment.
    if (counter_reset) begin
      st_nxt.count = `PTM_CNT_RESET;
    end else if (overflow) begin
      st_nxt.count = `PTM_CNT_RESET;
    end else if (tick) begin
      st_nxt.count = st_r.count + 16'h0001;
    end

    // First clearing step: a status read while the flag is set arms it.
    if (rd_commit && (reg_sel == ptm_pkg::REG_SC) && st_r.overflow_flag
        && !status_locked) begin
      st_nxt.clear_armed = 1'b1;
    end

    if (wr_commit && (reg_sel == ptm_pkg::REG_SC)) begin
      st_nxt.overflow_interrupt_enable = wbyte[`PTM_SC_IE_BIT];
      st_nxt.counter_stop = wbyte[`PTM_SC_STOP_BIT];
      st_nxt.prescaler_select = wbyte[`PTM_SC_PPS_MSB:`PTM_SC_PPS_LSB];
      // Writing one to the flag does nothing; only an armed zero clears.
      if (!wbyte[`PTM_SC_FLAG_BIT] && st_r.clear_armed && !status_locked) begin
        st_nxt.overflow_flag = 1'b0;
        st_nxt.clear_armed = 1'b0;
      end
    end

    if (wr_commit && (reg_sel == ptm_pkg::REG_MOD_HIGH)) begin
      st_nxt.modulo[`PTM_CNT_W-1:`PTM_BYTE_W] = wbyte;
      st_nxt.mod_high_pending = 1'b1;
    end

    if (wr_commit && (reg_sel == ptm_pkg::REG_MOD_LOW)) begin
      st_nxt.modulo[`PTM_BYTE_W-1:0] = wbyte;
      st_nxt.mod_high_pending = 1'b0;
    end

    // A fresh overflow disarms a pending clear and wins over the clear.
    if (flag_set) begin
      st_nxt.overflow_flag = 1'b1;
      st_nxt.clear_armed = 1'b0;
    end

    // The request is a level, so it can wake the core from wait mode.
    st_nxt.irq = st_nxt.overflow_flag & st_nxt.overflow_interrupt_enable;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.modulo <= `PTM_MOD_RESET;
      st_r.count <= `PTM_CNT_RESET;
      st_r.counter_stop <= 1'b1;
      st_r.prescaler_select <= `PTM_PPS_RESET;
      st_r.overflow_flag <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata  = st_r.rdata;
  assign pready  = st_r.ready;
  assign pslverr = st_r.slverr;
  assign irq     = st_r.irq;

endmodule

// *** tb/ptm_timer_asserts.sv ***
// Concurrent property checker for the periodic timer top module.
`include "ptm_defines.svh"
module ptm_timer_asserts #(
  parameter int ADDR_W = 12
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              brk_active,
  input wire logic              break_clear_enable,
  input wire logic              stop_mode,
  input wire logic              irq
);
  logic              wr_seen_r;
  logic              rd_done;
  logic              rd_sc;
  logic [ADDR_W-3:0] idx;
  assign idx = paddr[ADDR_W-1:2];
  assign rd_done = psel && penable && pready && !pwrite;
  assign rd_sc = rd_done && idx == (ADDR_W-2)'(`PTM_IDX_STATUS_CONTROL);
  // Until the first write every register must still show its reset value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_seen_r <= 1'b0;
    end else if (psel && pwrite) begin
      wr_seen_r <= 1'b1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_rst_bit_zero: assert property (rd_sc |-> !prdata[4])
    else $error("counter reset bit read back as one");
  chk_irq_gated: assert property (rd_sc && !prdata[6] |-> ##[0:1] !irq)
    else $error("request without enable");
  chk_irq_raised: assert property (rd_sc && prdata[7] && prdata[6] |-> ##[0:1] irq)
    else $error("request missing with flag and enable");
  chk_reset_quiet: assert property ($rose(presetn) |-> !irq && !pready && !pslverr)
    else $error("outputs active after reset");
  chk_stop_freeze: assert property (stop_mode && $past(stop_mode) && !psel && !$past(psel)
    |=> $stable(irq))
    else $error("request moved in stop mode");
  chk_break_freeze: assert property (brk_active && $past(brk_active) && !psel && !$past(psel)
    |=> $stable(irq))
    else $error("request moved in break");
  chk_status_reset: assert property (rd_sc && !wr_seen_r |-> prdata[7:0] == 8'h20)
    else $error("status reset value wrong");
  chk_modulo_ones: assert property (rd_done && !wr_seen_r
    && (idx == (ADDR_W-2)'(`PTM_IDX_MODULO_HIGH) || idx == (ADDR_W-2)'(`PTM_IDX_MODULO_LOW))
    |-> prdata[7:0] == 8'hff)
    else $error("modulo reset value wrong");
  chk_count_zero: assert property (rd_done && !wr_seen_r
    && (idx == (ADDR_W-2)'(`PTM_IDX_COUNT_HIGH) || idx == (ADDR_W-2)'(`PTM_IDX_COUNT_LOW))
    |-> prdata[7:0] == 8'h00)
    else $error("count reset value wrong");
endmodule
bind ptm_timer ptm_timer_asserts #(.ADDR_W(ADDR_W)) ptm_timer_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .brk_active(brk_active), .break_clear_enable(break_clear_enable),
  .stop_mode(stop_mode), .irq(irq));

// *** tb/ptm_timer_tb_top.sv ***
// Self-checking bench for the periodic timer and its register slave.
module ptm_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic       w;
    logic [7:0] ix;
    logic [7:0] d;
    logic [7:0] e;
    logic       er;
  } ptm_row_s;
  localparam logic [7:0] ix_sc = 8'h4b;
  localparam logic [7:0] ix_ch = 8'h4c;
  localparam logic [7:0] ix_cl = 8'h4d;
  localparam logic [7:0] ix_mh = 8'h4e;
  localparam logic [7:0] ix_ml = 8'h4f;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        brk_active, break_clear_enable, stop_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_fail, compares;
  ptm_row_s    rows [11] = '{
    '{1'b0, ix_sc, 8'h00, 8'h20, 1'b0}, '{1'b0, ix_ch, 8'h00, 8'h00, 1'b0},
    '{1'b0, ix_cl, 8'h00, 8'h00, 1'b0}, '{1'b0, ix_mh, 8'h00, 8'hff, 1'b0},
    '{1'b0, ix_ml, 8'h00, 8'hff, 1'b0}, '{1'b0, 8'h50, 8'h00, 8'h00, 1'b1},
    '{1'b1, ix_ch, 8'h55, 8'h00, 1'b0}, '{1'b0, ix_cl, 8'h00, 8'h00, 1'b0},
    '{1'b1, ix_sc, 8'h7e, 8'h00, 1'b0}, '{1'b0, ix_sc, 8'h00, 8'h66, 1'b0},
    '{1'b1, 8'h50, 8'h55, 8'h00, 1'b1}};

  ptm_timer ptm_timer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .brk_active(brk_active), .break_clear_enable(break_clear_enable),
    .stop_mode(stop_mode), .irq(irq));

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The slave's wait states are not assumed; a bounded wait guards against a hang.
  task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      $display("MISMATCH at %0t: ready %h expected %h", $time, pready, 1'b1);
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    brk_active = 1'b0;
    break_clear_enable = 1'b0;
    stop_mode = 1'b0;
    n_fail = 0;
    compares = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[k]) begin
      apb(rows[k].w, rows[k].ix, rows[k].d);
      if (!rows[k].w) chk(rd, {24'h0, rows[k].e});
      chk({31'h0, err}, {31'h0, rows[k].er});
    end
    $display("register table done");
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, ix_sc, 8'h30 | c[7:0]);
      apb(1'b1, ix_sc, c[7:0]);
      repeat (124) @(posedge pclk);
      apb(1'b1, ix_sc, 8'h20 | c[7:0]);
      apb(1'b0, ix_ch, 8'h00);
      apb(1'b0, ix_cl, 8'h00);
      chk(rd, 32'h80 >> ((c > 6) ? 6 : c));
    end
    $display("prescaler test done");
    apb(1'b1, ix_sc, 8'h30);
    apb(1'b0, ix_ch, 8'h00);
    apb(1'b1, ix_sc, 8'h00);
    repeat (20) @(posedge pclk);
    apb(1'b1, ix_sc, 8'h20);
    apb(1'b0, ix_ch, 8'h00);
    apb(1'b0, ix_cl, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, ix_cl, 8'h00);
    chk(rd, 32'h18);
    $display("count latch test done");
    apb(1'b1, ix_sc, 8'h30);
    apb(1'b1, ix_mh, 8'h00);
    apb(1'b1, ix_ml, 8'h00);
    apb(1'b1, ix_mh, 8'h00);
    apb(1'b1, ix_sc, 8'h40);
    repeat (8) @(posedge pclk);
    apb(1'b0, ix_sc, 8'h00);
    chk(rd, 32'h40);
    apb(1'b1, ix_ml, 8'h00);
    apb(1'b0, ix_sc, 8'h00);
    chk(rd, 32'hc0);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, ix_sc, 8'h40);
    apb(1'b0, ix_sc, 8'h00);
    chk(rd, 32'hc0);
    apb(1'b1, ix_sc, 8'h20);
    apb(1'b0, ix_sc, 8'h00);
    chk(rd, 32'ha0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, ix_sc, 8'ha0);
    apb(1'b0, ix_sc, 8'h00);
    chk(rd, 32'ha0);
    apb(1'b1, ix_sc, 8'h20);
    apb(1'b0, ix_sc, 8'h00);
    chk(rd, 32'h20);
    $display("flag test done");
    apb(1'b1, ix_sc, 8'h40);
    repeat (4) @(posedge pclk);
    stop_mode <= 1'b1;
    repeat (10) @(posedge pclk);
    stop_mode <= 1'b0;
    brk_active <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, ix_sc, 8'h00);
    apb(1'b1, ix_sc, 8'h40);
    apb(1'b0, ix_sc, 8'h00);
    chk(rd, 32'hc0);
    break_clear_enable <= 1'b1;
    apb(1'b0, ix_sc, 8'h00);
    apb(1'b1, ix_sc, 8'h40);
    apb(1'b0, ix_sc, 8'h00);
    chk(rd, 32'h40);
    // A high byte read in break must be released by a low byte read before leaving.
    apb(1'b0, ix_ch, 8'h00);
    apb(1'b0, ix_cl, 8'h00);
    chk(rd, 32'h0);
    brk_active <= 1'b0;
    break_clear_enable <= 1'b0;
    $display("break test done");
    stop_test();
  end
endmodule
